// *** design/pcs_top.sv ***
// Pixel correction, saturation detection and ROI stage with its AHB-Lite registers.
// Assumes pixels, coefficients and bus all on clk_sys_i; bus is zero-wait.
// What this block does
// (RULE1) Only pixels inside the active ROI feed the AGC statistics port.
// (RULE2) With the show option set the ROI outline is always drawn on analog video.
// (RULE3) ROI is set by x offset, y offset, width and height, each alone.
// (RULE4) The outline is drawn in a programmable grayscale level.
// (RULE5) ROI coordinates are sensor_array or display space, chosen by a bit.
// (RULE6) After boot the outline shows for a lifetime, then only with show set.
// (RULE7) Analog path has own gain, offset and bad-pixel enables; off steps bypass.
// (RULE8) Digital path has gain, offset and bad-pixel enables apart from analog.
// (RULE9) Analog polarity white-hot or black-hot; black-hot inverts the gray.
// (RULE10) A pixel is saturated when its raw count exceeds the raw threshold.
// (RULE11) Saturated count above the pixel threshold sets the frame header flag.
// (RULE12) The saturated pixel count is readable as status.
// (RULE13) Global gain and offset are applied to the digital image.
// (RULE14) Saturation counter clears at frame start, latches at frame end.
// (RULE15) Global gain multiplies first, then offset, then clip to pixel width.
`timescale 1ns/1ps
`default_nettype none
module pcs_top (
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    output logic [31:0]             hrdata_o,
    input  wire pcs_pkg::pcs_pix_t  pix_i,
    input  wire pcs_pkg::pcs_coef_t coef_i,
    output pcs_pkg::pcs_vid_t       ana_o,
    output pcs_pkg::pcs_pix_t       dig_o,
    output pcs_pkg::pcs_agc_t       agc_o,
    output logic                    sat_flag_o,
    output logic                    irq_o
);
    import pcs_pkg::*;

    typedef struct packed {
        logic             ready;
        logic             aw;
        logic [7:0]       waddr;
        logic [31:0]      rdata;
        logic [CTL_W-1:0] ctrl;
        logic [CRD_W-1:0] roi_x;
        logic [CRD_W-1:0] roi_y;
        logic [CRD_W-1:0] roi_w;
        logic [CRD_W-1:0] roi_h;
        logic [CRD_W-1:0] disp_x;
        logic [CRD_W-1:0] disp_y;
        logic [VID_W-1:0] color;
        logic [15:0]      life;
        logic [PIX_W-1:0] sat_raw;
        logic [CNT_W-1:0] sat_pix;
        logic [CNT_W-1:0] sat_run;
        logic [CNT_W-1:0] sat_cnt;
        logic [15:0]      ggain;
        logic [15:0]      goff;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imask;
        logic [CRD_W-1:0] px;
        logic [CRD_W-1:0] py;
        logic [15:0]      boot;
        logic             sat_flag;
        logic             irq;
        pcs_vid_t         ana;
        pcs_pix_t         dig;
        pcs_agc_t         agc;
    } pcs_top_st_t;

    pcs_top_st_t st_ff;
    pcs_top_st_t nxt_st;

    logic [PIX_W-1:0] acorr;
    logic [PIX_W-1:0] dcorr;
    logic [PIX_W-1:0] dglob;
    pcs_en_t          aen;
    pcs_en_t          den;

    // Separate enable sets per path [RULE7] [RULE8]
    assign aen = '{gain: st_ff.ctrl[CTL_AGAIN], off: st_ff.ctrl[CTL_AOFF],
                   bpr: st_ff.ctrl[CTL_ABPR]};
    assign den = '{gain: st_ff.ctrl[CTL_DGAIN], off: st_ff.ctrl[CTL_DOFF],
                   bpr: st_ff.ctrl[CTL_DBPR]};

    pcs_corr u_acorr (
        .raw_i  (pix_i.data),
        .coef_i (coef_i),
        .en_i   (aen),
        .pix_o  (acorr)
    );

    pcs_corr u_dcorr (
        .raw_i  (pix_i.data),
        .coef_i (coef_i),
        .en_i   (den),
        .pix_o  (dcorr)
    );

    // Gain before offset, clipped [RULE13] [RULE15]
    pcs_glob u_glob (
        .pix_i    (dcorr),
        .gain_i   (st_ff.ggain),
        .offset_i (st_ff.goff),
        .pix_o    (dglob)
    );

    function automatic logic [31:0] rd_word(input logic [7:0] a, input pcs_top_st_t s);
        logic [31:0] w;
        w = '0;
        unique case (a)
            REG_CTRL:     w = {23'h000000, s.ctrl};
            REG_ROI_POS:  w = {s.roi_y, s.roi_x};
            REG_ROI_SIZE: w = {s.roi_h, s.roi_w};
            REG_OVERLAY:  w = {s.life, 8'h00, s.color};
            REG_SAT_RAW:  w = {18'h00000, s.sat_raw};
            REG_SAT_PIX:  w = {12'h000, s.sat_pix};
            REG_SAT_CNT:  w = {12'h000, s.sat_cnt}; // [RULE12]
            REG_GLOBAL:   w = {s.goff, s.ggain};
            REG_IRQ_STAT: w = {30'h00000000, s.ist};
            REG_IRQ_MASK: w = {30'h00000000, s.imask};
            REG_DISP_ORG: w = {s.disp_y, s.disp_x};
            default:      w = '0;
        endcase
        return w;
    endfunction

    logic               addr_ok;
    logic [CRD_W-1:0]   cur_x;
    logic [CRD_W-1:0]   cur_y;
    logic signed [17:0] cx;
    logic signed [17:0] cy;
    logic signed [17:0] x0;
    logic signed [17:0] y0;
    logic signed [17:0] x1;
    logic signed [17:0] y1;
    logic               in_roi;
    logic               edge_px;
    logic               ovl_on;
    logic               sat_hit;
    logic [CNT_W-1:0]   run;
    logic [CNT_W-1:0]   final_cnt;
    logic               frame_end;
    logic               sat_set;
    logic [IRQ_W-1:0]   irq_set;
    logic [IRQ_W-1:0]   irq_clr;
    logic [VID_W-1:0]   gray;

    always_comb begin
        nxt_st    = st_ff;
        irq_clr   = '0;
        addr_ok   = hsel_i && hready_i && htrans_i[1];

        // Bus: address phase captured, write done in data phase
        nxt_st.ready = 1'b1;
        // Out-of-range writes must not alias onto the low registers
        nxt_st.aw    = addr_ok && hwrite_i && (haddr_i[31:8] == 24'h000000);
        if (addr_ok) begin
            nxt_st.waddr = {haddr_i[7:2], 2'b00};
        end
        if (addr_ok && !hwrite_i) begin
            nxt_st.rdata = (haddr_i[31:8] == 24'h000000) ?
                           rd_word({haddr_i[7:2], 2'b00}, st_ff) : 32'h00000000;
        end
        if (st_ff.aw) begin
            unique case (st_ff.waddr)
                REG_CTRL: begin
                    nxt_st.ctrl = hwdata_i[CTL_W-1:0];
                end
                REG_ROI_POS: begin
                    nxt_st.roi_x = hwdata_i[15:0]; // [RULE3]
                    nxt_st.roi_y = hwdata_i[31:16];
                end
                REG_ROI_SIZE: begin
                    nxt_st.roi_w = hwdata_i[15:0]; // [RULE3]
                    nxt_st.roi_h = hwdata_i[31:16];
                end
                REG_OVERLAY: begin
                    nxt_st.color = hwdata_i[7:0];
                    nxt_st.life  = hwdata_i[31:16];
                end
                REG_SAT_RAW: begin
                    nxt_st.sat_raw = hwdata_i[PIX_W-1:0];
                end
                REG_SAT_PIX: begin
                    nxt_st.sat_pix = hwdata_i[CNT_W-1:0];
                end
                REG_GLOBAL: begin
                    nxt_st.ggain = hwdata_i[15:0];
                    nxt_st.goff  = hwdata_i[31:16];
                end
                REG_IRQ_STAT: begin
                    irq_clr = hwdata_i[IRQ_W-1:0];
                end
                REG_IRQ_MASK: begin
                    nxt_st.imask = hwdata_i[IRQ_W-1:0];
                end
                REG_DISP_ORG: begin
                    nxt_st.disp_x = hwdata_i[15:0];
                    nxt_st.disp_y = hwdata_i[31:16];
                end
                default: begin
                end
            endcase
        end

        // Position of the current pixel; sof restarts both counters
        cur_x = pix_i.sof ? '0 : st_ff.px;
        cur_y = pix_i.sof ? '0 : st_ff.py;
        if (pix_i.valid) begin
            nxt_st.px = pix_i.eol ? '0 : cur_x + 16'h0001;
            nxt_st.py = pix_i.eol ? cur_y + 16'h0001 : cur_y;
        end

        // Display space is the sensor_array grid shifted by the display origin [RULE5]
        cx = $signed({2'b00, cur_x});
        cy = $signed({2'b00, cur_y});
        if (st_ff.ctrl[CTL_DISP]) begin
            cx = cx - $signed({2'b00, st_ff.disp_x});
            cy = cy - $signed({2'b00, st_ff.disp_y});
        end
        x0 = $signed({2'b00, st_ff.roi_x});
        y0 = $signed({2'b00, st_ff.roi_y});
        x1 = x0 + $signed({2'b00, st_ff.roi_w});
        y1 = y0 + $signed({2'b00, st_ff.roi_h});
        in_roi  = (cx >= x0) && (cx < x1) && (cy >= y0) && (cy < y1);
        edge_px = in_roi && ((cx == x0) || (cx == x1 - 18'sd1) ||
                             (cy == y0) || (cy == y1 - 18'sd1));

        // Boot lifetime counted in frames; show bit overrides [RULE6] [RULE2]
        ovl_on = st_ff.ctrl[CTL_SHOW] || (st_ff.boot < st_ff.life);
        frame_end = pix_i.valid && pix_i.eof;
        if (frame_end && (st_ff.boot != 16'hFFFF)) begin
            nxt_st.boot = st_ff.boot + 16'h0001;
        end

        // Saturation count per frame [RULE10] [RULE14]
        sat_hit   = pix_i.valid && (pix_i.data > st_ff.sat_raw);
        run       = pix_i.sof ? '0 : st_ff.sat_run;
        final_cnt = run + {{(CNT_W-1){1'b0}}, sat_hit};
        if (pix_i.valid) begin
            nxt_st.sat_run = final_cnt;
        end
        sat_set = frame_end && (final_cnt > st_ff.sat_pix); // [RULE11]
        if (frame_end) begin
            nxt_st.sat_cnt  = final_cnt;
            nxt_st.sat_flag = sat_set;
        end

        // Sticky events, a set in the clearing cycle survives
        irq_set = '0;
        irq_set[IRQ_FRAME] = frame_end;
        irq_set[IRQ_SAT]   = sat_set;
        nxt_st.ist = (st_ff.ist & ~irq_clr) | irq_set;
        nxt_st.irq = |(nxt_st.ist & nxt_st.imask);

        // Analog video: polarity, then outline on top [RULE9] [RULE4]
        gray = acorr[PIX_W-1:PIX_W-VID_W];
        if (st_ff.ctrl[CTL_BLACK]) begin
            gray = ~gray;
        end
        if (ovl_on && edge_px) begin
            gray = st_ff.color;
        end
        nxt_st.ana = '{valid: pix_i.valid, sof: pix_i.sof, eof: pix_i.eof,
                       data: pix_i.valid ? gray : '0};

        // Digital output after global stage
        nxt_st.dig = '{valid: pix_i.valid, sof: pix_i.sof, eol: pix_i.eol,
                       eof: pix_i.eof, data: pix_i.valid ? dglob : '0};

        // AGC sees only ROI pixels, taken after analog correction [RULE1]
        nxt_st.agc = '{valid: pix_i.valid && in_roi,
                       data: (pix_i.valid && in_roi) ? acorr : '0};
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_ff         <= '0;
            st_ff.ctrl    <= CTRL_RST;
            st_ff.roi_w   <= ROI_W_RST;
            st_ff.roi_h   <= ROI_H_RST;
            st_ff.color   <= COLOR_RST;
            st_ff.life    <= LIFE_RST;
            st_ff.sat_raw <= SRAW_RST;
            st_ff.sat_pix <= SPIX_RST;
            st_ff.ggain   <= GGAIN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // The bus never stalls or errors, so one ready flop is enough and hresp_o stays 0
    assign hreadyout_o = st_ff.ready;
    assign hresp_o     = 1'b0 & st_ff.ready;
    assign hrdata_o    = st_ff.rdata;
    assign ana_o       = st_ff.ana;
    assign dig_o       = st_ff.dig;
    assign agc_o       = st_ff.agc;
    assign sat_flag_o  = st_ff.sat_flag;
    assign irq_o       = st_ff.irq;
endmodule
`default_nettype wire

// *** design/pcs_pkg.sv ***
// Constants and carrier types of the pixel correction, saturation and ROI stage.
// Assumes one pixel clock domain; all users import the whole package.
package pcs_pkg;
    localparam int PIX_W  = 14;
    localparam int VID_W  = 8;
    localparam int CNT_W  = 20;
    localparam int CRD_W  = 16;
    localparam int NUC_FRAC = 14;
    localparam int GLB_FRAC = 8;
    localparam logic [PIX_W-1:0] PIX_MAX = 14'h3FFF;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ROI_POS  = 8'h04;
    localparam logic [7:0] REG_ROI_SIZE = 8'h08;
    localparam logic [7:0] REG_OVERLAY  = 8'h0C;
    localparam logic [7:0] REG_SAT_RAW  = 8'h10;
    localparam logic [7:0] REG_SAT_PIX  = 8'h14;
    localparam logic [7:0] REG_SAT_CNT  = 8'h18;
    localparam logic [7:0] REG_GLOBAL   = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h24;
    localparam logic [7:0] REG_DISP_ORG = 8'h28;

    // Control and interrupt bit positions
    localparam int CTL_SHOW  = 0;
    localparam int CTL_DISP  = 1;
    localparam int CTL_AGAIN = 2;
    localparam int CTL_AOFF  = 3;
    localparam int CTL_ABPR  = 4;
    localparam int CTL_BLACK = 5;
    localparam int CTL_DGAIN = 6;
    localparam int CTL_DOFF  = 7;
    localparam int CTL_DBPR  = 8;
    localparam int CTL_W     = 9;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_SAT   = 1;
    localparam int IRQ_W     = 2;

    // Reset values
    localparam logic [CTL_W-1:0] CTRL_RST  = 9'h1DC;
    localparam logic [CRD_W-1:0] ROI_W_RST = 16'h0280;
    localparam logic [CRD_W-1:0] ROI_H_RST = 16'h01E0;
    localparam logic [VID_W-1:0] COLOR_RST = 8'hFF;
    localparam logic [15:0]      LIFE_RST  = 16'h0258;
    localparam logic [PIX_W-1:0] SRAW_RST  = 14'h2EE0;
    localparam logic [CNT_W-1:0] SPIX_RST  = 20'h007D0;
    localparam logic [15:0]      GGAIN_RST = 16'h0100;

    typedef struct packed {
        logic             valid;
        logic             sof;
        logic             eol;
        logic             eof;
        logic [PIX_W-1:0] data;
    } pcs_pix_t;

    typedef struct packed {
        logic [15:0]      gain;
        logic [15:0]      offset;
        logic             bad;
        logic [PIX_W-1:0] repl;
    } pcs_coef_t;

    typedef struct packed {
        logic gain;
        logic off;
        logic bpr;
    } pcs_en_t;

    typedef struct packed {
        logic             valid;
        logic             sof;
        logic             eof;
        logic [VID_W-1:0] data;
    } pcs_vid_t;

    typedef struct packed {
        logic             valid;
        logic [PIX_W-1:0] data;
    } pcs_agc_t;
endpackage

// *** design/pcs_corr.sv ***
// Per-pixel nonuniformity_correction gain, offset and bad-pixel replacement.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pcs_corr (
    input  wire logic [pcs_pkg::PIX_W-1:0] raw_i,
    input  wire pcs_pkg::pcs_coef_t        coef_i,
    input  wire pcs_pkg::pcs_en_t          en_i,
    output logic [pcs_pkg::PIX_W-1:0]      pix_o
);
    import pcs_pkg::*;
    logic [29:0]        prod;
    logic [15:0]        gained;
    logic signed [17:0] sum;

    always_comb begin
        prod   = 30'({16'h0000, raw_i} * {14'h0000, coef_i.gain});
        // Disabled steps pass through untouched
        gained = en_i.gain ? prod[NUC_FRAC+15:NUC_FRAC] : {2'b00, raw_i};
        sum    = $signed({2'b00, gained});
        if (en_i.off) begin
            sum = sum + 18'($signed(coef_i.offset));
        end
        if (sum < 18'sd0) begin
            pix_o = '0;
        end else if (sum > $signed({4'h0, PIX_MAX})) begin
            pix_o = PIX_MAX;
        end else begin
            pix_o = sum[PIX_W-1:0];
        end
        if (en_i.bpr && coef_i.bad) begin
            pix_o = coef_i.repl;
        end
    end
endmodule
`default_nettype wire

// *** design/pcs_glob.sv ***
// Global gain (unsigned 8.8) then signed offset, clipped to the pixel range.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pcs_glob (
    input  wire logic [pcs_pkg::PIX_W-1:0] pix_i,
    input  wire logic [15:0]               gain_i,
    input  wire logic [15:0]               offset_i,
    output logic [pcs_pkg::PIX_W-1:0]      pix_o
);
    import pcs_pkg::*;
    logic [29:0]        prod;
    logic signed [23:0] sum;

    always_comb begin
        prod  = 30'({16'h0000, pix_i} * {14'h0000, gain_i});
        sum   = $signed({2'b00, prod[GLB_FRAC+21:GLB_FRAC]}) + 24'($signed(offset_i));
        if (sum < 24'sd0) begin
            pix_o = '0;
        end else if (sum > $signed({10'h000, PIX_MAX})) begin
            pix_o = PIX_MAX;
        end else begin
            pix_o = sum[PIX_W-1:0];
        end
    end
endmodule
`default_nettype wire

// *** test/pcs_properties.sv ***
// Checker for the pixel stream timing of pcs_top.
// Assumes one clock domain and is bound to every pcs_top instance.
`timescale 1ns/1ps
`default_nettype none
module pcs_properties (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire pcs_pkg::pcs_pix_t pix_i,
    input  wire pcs_pkg::pcs_vid_t ana_o,
    input  wire pcs_pkg::pcs_pix_t dig_o,
    input  wire pcs_pkg::pcs_agc_t agc_o,
    input  wire logic              sat_flag_o
);
    import pcs_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence pix_in;
        pix_i.valid;
    endsequence
    sequence eof_in;
        pix_i.valid && pix_i.eof;
    endsequence
    a_ana_timing: assert property (pix_in |=> ana_o.valid)
        else $error("analog pixel missing one cycle after input");
    a_dig_timing: assert property (pix_in |=> dig_o.valid)
        else $error("digital pixel missing one cycle after input");
    a_idle_quiet: assert property (!pix_i.valid |=> !(dig_o.valid || ana_o.valid || agc_o.valid))
        else $error("output pixel without an input pixel");
    a_ana_blank: assert property (!pix_i.valid |=> ana_o.data == 8'h00)
        else $error("analog data not zero between pixels");
    a_sof_marks: assert property (pix_i.valid && pix_i.sof |=> dig_o.sof && ana_o.sof)
        else $error("frame start not passed on");
    a_eof_marks: assert property (eof_in |=> dig_o.eof && ana_o.eof)
        else $error("frame end not passed on");
    a_eol_marks: assert property (pix_i.valid && pix_i.eol |=> dig_o.eol)
        else $error("line end not passed on");
    a_flag_frame: assert property ($changed(sat_flag_o) |-> $past(pix_i.valid && pix_i.eof))
        else $error("saturation flag moved away from frame end");
endmodule
bind pcs_top pcs_properties u_props (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .pix_i      (pix_i),
    .ana_o      (ana_o),
    .dig_o      (dig_o),
    .agc_o      (agc_o),
    .sat_flag_o (sat_flag_o)
);
`default_nettype wire

// *** test/pcs_src.sv ***
// Behavioural sensor_array pixel source with per-pixel coefficients.
// Assumes a go pulse per frame; slow mode leaves a gap before every pixel.
`timescale 1ns/1ps
`default_nettype none
module pcs_src #(
    parameter int W = 8,
    parameter int H = 4
) (
    input  wire logic               clk_i,
    input  wire logic               go_i,
    input  wire logic               slow_i,
    input  wire logic [13:0]        base_i,
    output pcs_pkg::pcs_pix_t       pix_o,
    output pcs_pkg::pcs_coef_t      coef_o,
    output logic                    busy_o
);
    import pcs_pkg::*;
    initial begin
        pix_o = '0;
        coef_o = '0;
        busy_o = 1'b0;
    end
    // Idle lines show inverted data so stale values never pass as valid
    always begin
        @(posedge clk_i);
        if (go_i) begin
            busy_o <= 1'b1;
            for (int y = 0; y < H; y++) begin
                for (int x = 0; x < W; x++) begin
                    if (slow_i) begin
                        pix_o <= {1'b0, ~pix_o[16:0]};
                        @(posedge clk_i);
                    end
                    pix_o <= '{1'b1, x == 0 && y == 0, x == W - 1, x == W - 1 && y == H - 1,
                               base_i + 14'(x * 256 + y)};
                    coef_o <= '{16'(16'h4000 + x * 512), 16'((x - y) * 40), x == y, 14'h0123};
                    @(posedge clk_i);
                end
            end
            pix_o <= {1'b0, ~pix_o[16:0]};
            coef_o <= ~coef_o;
            busy_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** test/pcs_top_tb.sv ***
// Self-checking bench: AHB-Lite register traffic and random pixel frames.
// Assumes pcs_src as the pixel source and pcs_properties bound to the design.
`timescale 1ns/1ps
`default_nettype none
module pcs_top_tb;
    import pcs_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready, hresp, busy, sat_flag, irq, eflag;
    logic [31:0] hrdata, rd;
    logic        go = 1'b0;
    logic        slow = 1'b0;
    logic [13:0] base = 14'h0;
    pcs_pix_t    pix, dig;
    pcs_coef_t   coef;
    pcs_vid_t    ana;
    pcs_agc_t    agc;
    logic [31:0] mir [11] = '{32'h1DC, 32'h0, 32'h01E0_0280, 32'h0258_00FF, 32'h2EE0,
                              32'h7D0, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
    logic [31:0] odd [3] = '{32'h2C, 32'h104, 32'h18};
    logic [36:0] expq [$];
    logic [31:0] lfsr = 32'hAF3E;
    int          err_count = 0;
    int          checks = 0;
    int          px, py, frames, sc, ecnt;

    always #4 clk_sys_i = ~clk_sys_i;

    pcs_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .pix_i(pix), .coef_i(coef), .ana_o(ana), .dig_o(dig), .agc_o(agc),
        .sat_flag_o(sat_flag), .irq_o(irq));
    pcs_src SRC (.clk_i(clk_sys_i), .go_i(go), .slow_i(slow), .base_i(base),
        .pix_o(pix), .coef_o(coef), .busy_o(busy));

    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int clip(int v);
        return v < 0 ? 0 : (v > 16383 ? 16383 : v);
    endfunction
    function automatic int nonuniformity_correction(int r, pcs_coef_t c, logic g, logic o, logic b);
        int v;
        v = g ? (r * int'(c.gain)) >>> 14 : r;
        if (o) v = v + int'($signed(c.offset));
        v = clip(v);
        return (b && c.bad) ? int'(c.repl) : v;
    endfunction
    task automatic fail(string m);
        err_count++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic print_verdict();
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Single transfer; the mirror skips read-only and write-one-to-clear places
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
        checks++;
        if (hresp !== 1'b0) fail("bus response not OKAY");
        if (w && a < 32'h2C && a != 32'h18 && a != 32'h20) mir[a[5:2]] = d;
    endtask
    task automatic frame();
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        @(posedge clk_sys_i);
        while (busy === 1'b1) @(posedge clk_sys_i);
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Expected results, noted from the pixels handed to the design
    always @(negedge clk_sys_i) begin
        int a, d, cx, cy, x0, y0, w, h;
        logic [7:0] g;
        logic in;
        if (pix.valid === 1'b1) begin
            if (pix.sof) begin
                px = 0;
                py = 0;
            end
            a = nonuniformity_correction(pix.data, coef, mir[0][CTL_AGAIN], mir[0][CTL_AOFF], mir[0][CTL_ABPR]);
            d = nonuniformity_correction(pix.data, coef, mir[0][CTL_DGAIN], mir[0][CTL_DOFF], mir[0][CTL_DBPR]);
            d = clip(((d * int'(mir[7][15:0])) >>> 8) + int'($signed(mir[7][31:16])));
            g = 8'(a >> 6) ^ {8{mir[0][CTL_BLACK]}};
            cx = px - (mir[0][CTL_DISP] ? int'(mir[10][15:0]) : 0);
            cy = py - (mir[0][CTL_DISP] ? int'(mir[10][31:16]) : 0);
            x0 = int'(mir[1][15:0]);
            y0 = int'(mir[1][31:16]);
            w = int'(mir[2][15:0]);
            h = int'(mir[2][31:16]);
            in = cx >= x0 && cx < x0 + w && cy >= y0 && cy < y0 + h;
            if (in && (mir[0][CTL_SHOW] || frames < int'(mir[3][31:16]))
                && (cx == x0 || cy == y0 || cx == x0 + w - 1 || cy == y0 + h - 1)) begin
                g = mir[3][7:0];
            end
            expq.push_back({14'(d), g, in, in ? 14'(a) : 14'h0});
            sc += (pix.data > mir[4][13:0]);
            if (pix.eof) begin
                eflag = sc > int'(mir[5][19:0]);
                ecnt = sc;
                sc = 0;
                frames++;
            end
            if (pix.eol) begin
                px = 0;
                py++;
            end else px++;
        end
    end

    always @(negedge clk_sys_i) begin
        logic [36:0] e;
        if (dig.valid === 1'b1) begin
            checks++;
            if (expq.size() == 0) fail("pixel out without pixel in");
            else begin
                e = expq.pop_front();
                if ({dig.data, ana.data, agc.valid, agc.valid ? agc.data : 14'h0} !== e) fail("pixel value");
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail("timeout");
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 11; i++) begin
            bus(32'(i * 4), 1'b0, 32'h0);
            checks++;
            if (rd !== mir[i]) fail("reset value");
        end
        bus(32'h18, 1'b1, 32'h000F_FFFF);
        for (int i = 0; i < 3; i++) begin
            bus(odd[i], 1'b0, 32'h0);
            checks++;
            if (rd !== 32'h0) fail("unmapped or read-only place");
        end
        bus(32'h104, 1'b1, 32'hFFFF_FFFF);
        bus(32'h04, 1'b0, 32'h0);
        checks++;
        if (rd !== mir[1]) fail("out-of-range write landed");
        lfsr = nxt(lfsr);
        base <= {1'b0, lfsr[12:0]};
        frame();
        checks++;
        if (irq !== 1'b0) fail("masked interrupt raised");
        bus(32'h24, 1'b1, 32'h3);
        bus(32'h28, 1'b1, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            bus(32'h00, 1'b1, {23'h0, lfsr[8:0]});
            bus(32'h1C, 1'b1, {{8{lfsr[7]}}, lfsr[7:0], 7'h0, lfsr[24:16]});
            lfsr = nxt(lfsr);
            bus(32'h0C, 1'b1, {12'h0, lfsr[3:0], 8'h0, lfsr[15:8]});
            bus(32'h04, 1'b1, {16'(i % 2), 16'(i % 3)});
            bus(32'h08, 1'b1, {16'(2 + i % 3), 16'(3 + i % 4)});
            lfsr = nxt(lfsr);
            base <= {1'b0, lfsr[12:0]};
            bus(32'h10, 1'b1, {18'h0, {1'b0, lfsr[12:0]} + 14'h0300});
            bus(32'h14, 1'b1, 32'(i * 3));
            slow <= i[0];
            frame();
            checks++;
            if (sat_flag !== eflag) fail("saturation flag");
            bus(32'h18, 1'b0, 32'h0);
            checks++;
            if (rd !== 32'(ecnt)) fail("saturation count");
            checks++;
            if (irq !== 1'b1) fail("interrupt not raised");
            bus(32'h20, 1'b0, 32'h0);
            checks++;
            if (rd !== {30'h0, eflag, 1'b1}) fail("interrupt status");
            bus(32'h20, 1'b1, 32'h3);
            repeat (2) @(posedge clk_sys_i);
            checks++;
            if (irq !== 1'b0) fail("interrupt not cleared");
        end
        print_verdict();
    end
endmodule
`default_nettype wire
